/* File: pcd_port_regs.sv */
// Port register slice: priority-3 ingress limits, PHY special control and cable test results.
//
// Behaviour
// - Each port holds a seven-bit writable priority-3 ingress limit, reset to zero.
// - Bit 7 of the special register flags a short within ten meters.
// - Two-bit outcome reports normal, open, short or failed, reset to zero.
// - Writing one to bit 4 starts the test; hardware clears it when finished.
// - Bit 3 forces link pass; clear gives normal link detection.
// - Bit 1 loops received traffic back through the PHY medium layers.
// - Nine-bit fault count: bit 8 in special bit 0, low byte next register.
// - Fault distance is about 0.4 meter per count unit.
// - Port 3 has no special or result register; those addresses read zero.
module pcd_port_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic [6:0] p1_prio3_limit,
	output logic [6:0] p2_prio3_limit,
	output logic [6:0] p3_prio3_limit,
	output logic [1:0] force_link,
	output logic [1:0] remote_loop,
	output logic [1:0] diag_start,
	input wire logic [1:0] phy_done,
	input wire logic [3:0] phy_outcome,
	input wire logic [1:0] phy_near_short,
	input wire logic [17:0] phy_fault_count
);

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic logic [7:0] special_word(input logic short_f, input logic [1:0] outc,
			input logic busy, input logic frc, input logic loopb, input logic [8:0] cnt);
		logic [7:0] w;
		w = 8'h00;
		w[pcd_pkg::NEAR_SHORT_BIT] = short_f;
		w[pcd_pkg::OUTCOME_HI:pcd_pkg::OUTCOME_LO] = outc;
		w[pcd_pkg::TEST_START_BIT] = busy;
		w[pcd_pkg::FORCE_LINK_BIT] = frc;
		w[pcd_pkg::RSVD_SPECIAL_BIT] = 1'b0;
		w[pcd_pkg::REMOTE_LOOP_BIT] = loopb;
		w[pcd_pkg::FAULT_MSB_BIT] = cnt[8];
		return w;
	endfunction : special_word

	function automatic logic [7:0] limit_word(input logic [6:0] lim);
		return {1'b0, lim};
	endfunction : limit_word

	// ****************************************
	// Writable control state
	// ****************************************
	logic [6:0] lim1_q, lim1_d, lim2_q, lim2_d, lim3_q, lim3_d;
	logic [1:0] frc_q, frc_d, loop_q, loop_d;
	logic [1:0] start_q, start_d;
	logic [1:0] busy;

	always_comb begin
		lim1_d = lim1_q;
		lim2_d = lim2_q;
		lim3_d = lim3_q;
		frc_d = frc_q;
		loop_d = loop_q;
		start_d = 2'h0;
		if (reg_wr) begin
			case (reg_addr)
				pcd_pkg::P1_PRIO3_LIMIT_OFS: lim1_d = reg_wdata[6:0];
				pcd_pkg::P2_PRIO3_LIMIT_OFS: lim2_d = reg_wdata[6:0];
				pcd_pkg::P3_PRIO3_LIMIT_OFS: lim3_d = reg_wdata[6:0];
				pcd_pkg::P1_PHY_SPECIAL_OFS: begin
					frc_d[0] = reg_wdata[pcd_pkg::FORCE_LINK_BIT];
					loop_d[0] = reg_wdata[pcd_pkg::REMOTE_LOOP_BIT];
					start_d[0] = reg_wdata[pcd_pkg::TEST_START_BIT] & ~busy[0];
				end
				pcd_pkg::P2_PHY_SPECIAL_OFS: begin
					frc_d[1] = reg_wdata[pcd_pkg::FORCE_LINK_BIT];
					loop_d[1] = reg_wdata[pcd_pkg::REMOTE_LOOP_BIT];
					start_d[1] = reg_wdata[pcd_pkg::TEST_START_BIT] & ~busy[1];
				end
				default: begin
					// Port 3 reserved addresses and unmapped ones ignore writes.
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lim1_q <= pcd_pkg::LIMIT_RST;
			lim2_q <= pcd_pkg::LIMIT_RST;
			lim3_q <= pcd_pkg::LIMIT_RST;
			frc_q <= 2'h0;
			loop_q <= 2'h0;
			start_q <= 2'h0;
		end else begin
			lim1_q <= lim1_d;
			lim2_q <= lim2_d;
			lim3_q <= lim3_d;
			frc_q <= frc_d;
			loop_q <= loop_d;
			start_q <= start_d;
		end
	end

	assign p1_prio3_limit = lim1_q;
	assign p2_prio3_limit = lim2_q;
	assign p3_prio3_limit = lim3_q;
	assign force_link = frc_q;
	assign remote_loop = loop_q;
	assign diag_start = start_q;

	// ****************************************
	// Per-port cable test slices
	// ****************************************
	pcd_diag_if dif1 ();
	pcd_diag_if dif2 ();

	assign dif1.start = start_q[0];
	assign dif1.phy_done = phy_done[0];
	assign dif1.phy_outcome = phy_outcome[1:0];
	assign dif1.phy_near_short = phy_near_short[0];
	assign dif1.phy_fault_count = phy_fault_count[8:0];
	assign dif2.start = start_q[1];
	assign dif2.phy_done = phy_done[1];
	assign dif2.phy_outcome = phy_outcome[3:2];
	assign dif2.phy_near_short = phy_near_short[1];
	assign dif2.phy_fault_count = phy_fault_count[17:9];

	pcd_diag_port u_diag1 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.dif(dif1)
	);

	pcd_diag_port u_diag2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.dif(dif2)
	);

	// The start bit reads one from the write until the test completes.
	assign busy = {dif2.busy | start_q[1], dif1.busy | start_q[0]};

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] rd_q, rd_d;

	always_comb begin
		rd_d = rd_q;
		if (reg_rd) begin
			case (reg_addr)
				pcd_pkg::P1_PRIO3_LIMIT_OFS: rd_d = limit_word(lim1_q);
				pcd_pkg::P2_PRIO3_LIMIT_OFS: rd_d = limit_word(lim2_q);
				pcd_pkg::P3_PRIO3_LIMIT_OFS: rd_d = limit_word(lim3_q);
				pcd_pkg::P1_PHY_SPECIAL_OFS: rd_d = special_word(dif1.near_short_flag,
					dif1.outcome, busy[0], frc_q[0], loop_q[0], dif1.fault_count);
				pcd_pkg::P2_PHY_SPECIAL_OFS: rd_d = special_word(dif2.near_short_flag,
					dif2.outcome, busy[1], frc_q[1], loop_q[1], dif2.fault_count);
				pcd_pkg::P1_FAULT_DIST_OFS: rd_d = dif1.fault_count[7:0];
				pcd_pkg::P2_FAULT_DIST_OFS: rd_d = dif2.fault_count[7:0];
				pcd_pkg::P3_RSVD_SPECIAL_OFS: rd_d = pcd_pkg::RSVD_READ;
				pcd_pkg::P3_RSVD_RESULT_OFS: rd_d = pcd_pkg::RSVD_READ;
				default: rd_d = pcd_pkg::RSVD_READ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_q <= 8'h00;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign reg_rdata = rd_q;

	// ****************************************
	// Checks
	// ****************************************
	chk_reset_clear: assert property (@(posedge ref_clk)
		!rst_n |=> reg_rdata == 8'h00 && diag_start == 2'h0 && force_link == 2'h0
		&& remote_loop == 2'h0 && p1_prio3_limit == pcd_pkg::LIMIT_RST
		&& p2_prio3_limit == pcd_pkg::LIMIT_RST && p3_prio3_limit == pcd_pkg::LIMIT_RST)
		else $error("Outputs not cleared by reset.");
	chk_limit_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P1_PRIO3_LIMIT_OFS)
		|=> p1_prio3_limit == $past(reg_wdata[6:0]))
		else $error("Priority-3 limit write not stored.");
	chk_limit_write_p2: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P2_PRIO3_LIMIT_OFS)
		|=> p2_prio3_limit == $past(reg_wdata[6:0]))
		else $error("Port 2 priority-3 limit write not stored.");
	chk_limit_write_p3: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P3_PRIO3_LIMIT_OFS)
		|=> p3_prio3_limit == $past(reg_wdata[6:0]))
		else $error("Port 3 priority-3 limit write not stored.");
	chk_limit_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!reg_wr |=> $stable(p1_prio3_limit) && $stable(p2_prio3_limit)
		&& $stable(p3_prio3_limit))
		else $error("Priority-3 limit changed without a write.");
	chk_limit_top_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P2_PRIO3_LIMIT_OFS)
		|=> reg_rdata == {1'b0, p2_prio3_limit})
		else $error("Limit read shows wrong value or top bit set.");
	chk_limit_read_p3: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P3_PRIO3_LIMIT_OFS)
		|=> reg_rdata == {1'b0, p3_prio3_limit})
		else $error("Port 3 limit read shows wrong value or top bit set.");
	chk_force_link: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P2_PHY_SPECIAL_OFS)
		|=> force_link[1] == $past(reg_wdata[pcd_pkg::FORCE_LINK_BIT])
		&& remote_loop[1] == $past(reg_wdata[pcd_pkg::REMOTE_LOOP_BIT]))
		else $error("Force link or loopback bit not stored.");
	chk_loop_store_p1: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P1_PHY_SPECIAL_OFS)
		|=> remote_loop[0] == $past(reg_wdata[pcd_pkg::REMOTE_LOOP_BIT])
		&& force_link[0] == $past(reg_wdata[pcd_pkg::FORCE_LINK_BIT]))
		else $error("Port 1 loopback or force link bit not stored.");
	chk_special_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P1_PHY_SPECIAL_OFS)
		|=> reg_rdata[pcd_pkg::RSVD_SPECIAL_BIT] == 1'b0
		&& reg_rdata[pcd_pkg::REMOTE_LOOP_BIT] == remote_loop[0])
		else $error("Special register read is wrong.");
	chk_special_read_p2: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P2_PHY_SPECIAL_OFS)
		|=> reg_rdata[pcd_pkg::RSVD_SPECIAL_BIT] == 1'b0
		&& reg_rdata[pcd_pkg::FORCE_LINK_BIT] == force_link[1])
		else $error("Port 2 special register read is wrong.");
	chk_p3_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && (reg_addr == pcd_pkg::P3_RSVD_SPECIAL_OFS
		|| reg_addr == pcd_pkg::P3_RSVD_RESULT_OFS)) |=> reg_rdata == 8'h00)
		else $error("Port 3 reserved address read non-zero.");
	chk_p3_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && (reg_addr == pcd_pkg::P3_RSVD_SPECIAL_OFS
		|| reg_addr == pcd_pkg::P3_RSVD_RESULT_OFS))
		|=> $stable(force_link) && $stable(remote_loop) && diag_start == 2'h0)
		else $error("Write to a port 3 reserved address changed control state.");

	// ****************************************
	// Cable test checks
	// ****************************************
	chk_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P1_PHY_SPECIAL_OFS
		&& reg_wdata[pcd_pkg::TEST_START_BIT] && !busy[0])
		|=> diag_start[0] ##1 busy[0])
		else $error("Test launch did not start port 1 diagnostic.");
	chk_start_pulse_p2: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P2_PHY_SPECIAL_OFS
		&& reg_wdata[pcd_pkg::TEST_START_BIT] && !busy[1])
		|=> diag_start[1] ##1 busy[1])
		else $error("Test launch did not start port 2 diagnostic.");
	chk_start_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == pcd_pkg::P1_PHY_SPECIAL_OFS && busy[0])
		|=> !diag_start[0])
		else $error("Launch write accepted while port 1 test was running.");
	chk_start_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(busy[0] && phy_done[0] && !start_q[0]) |=> !busy[0])
		else $error("Launch bit not cleared after completion.");
	chk_start_clear_p2: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(busy[1] && phy_done[1] && !start_q[1]) |=> !busy[1])
		else $error("Port 2 launch bit not cleared after completion.");
	chk_short_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P2_PHY_SPECIAL_OFS)
		|=> reg_rdata[pcd_pkg::NEAR_SHORT_BIT] == $past(dif2.near_short_flag))
		else $error("Near short flag read is wrong.");
	chk_outcome_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P2_PHY_SPECIAL_OFS)
		|=> reg_rdata[pcd_pkg::OUTCOME_HI:pcd_pkg::OUTCOME_LO] == $past(dif2.outcome))
		else $error("Cable test outcome read is wrong.");
	chk_fault_msb: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P1_PHY_SPECIAL_OFS)
		|=> reg_rdata[pcd_pkg::FAULT_MSB_BIT] == $past(dif1.fault_count[8]))
		else $error("Fault count top bit read is wrong.");
	chk_fault_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P2_FAULT_DIST_OFS)
		|=> reg_rdata == $past(dif2.fault_count[7:0]))
		else $error("Fault distance low byte read is wrong.");
	chk_fault_low_p1: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == pcd_pkg::P1_FAULT_DIST_OFS)
		|=> reg_rdata == $past(dif1.fault_count[7:0]))
		else $error("Port 1 fault distance low byte read is wrong.");

	// ****************************************
	// Cover points
	// ****************************************
	cov_start_refused: cover property (@(posedge ref_clk) disable iff (!rst_n)
		reg_wr && reg_addr == pcd_pkg::P2_PHY_SPECIAL_OFS
		&& reg_wdata[pcd_pkg::TEST_START_BIT] && busy[1]);
	cov_mid_test_reset: cover property (@(posedge ref_clk) !rst_n && busy[0]);
	cov_test_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
		diag_start[0] ##[1:50] (busy[0] && phy_done[0]));
	cov_short_found: cover property (@(posedge ref_clk) disable iff (!rst_n)
		phy_done[1] && busy[1] && phy_near_short[1]);
	cov_force_loop: cover property (@(posedge ref_clk) disable iff (!rst_n)
		force_link[0] && remote_loop[0]);

endmodule : pcd_port_regs

/* File: pcd_pkg.sv */
// Package with register map, field layout and result codes of the port cable diagnostic slice.
package pcd_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] P1_PRIO3_LIMIT_OFS = 8'h19;
	localparam logic [7:0] P1_PHY_SPECIAL_OFS = 8'h1A;
	localparam logic [7:0] P1_FAULT_DIST_OFS = 8'h1B;
	localparam logic [7:0] P2_PRIO3_LIMIT_OFS = 8'h29;
	localparam logic [7:0] P2_PHY_SPECIAL_OFS = 8'h2A;
	localparam logic [7:0] P2_FAULT_DIST_OFS = 8'h2B;
	localparam logic [7:0] P3_PRIO3_LIMIT_OFS = 8'h39;
	localparam logic [7:0] P3_RSVD_SPECIAL_OFS = 8'h3A;
	localparam logic [7:0] P3_RSVD_RESULT_OFS = 8'h3B;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int LIMIT_W = 7;
	localparam int NEAR_SHORT_BIT = 7;
	localparam int OUTCOME_HI = 6;
	localparam int OUTCOME_LO = 5;
	localparam int TEST_START_BIT = 4;
	localparam int FORCE_LINK_BIT = 3;
	localparam int RSVD_SPECIAL_BIT = 2;
	localparam int REMOTE_LOOP_BIT = 1;
	localparam int FAULT_MSB_BIT = 0;
	localparam int FAULT_W = 9;
	localparam logic [6:0] LIMIT_RST = 7'h00;
	localparam logic [8:0] FAULT_RST = 9'h000;
	localparam logic [7:0] RSVD_READ = 8'h00;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PCD_OUT_NORMAL = 2'h0,
		PCD_OUT_OPEN = 2'h1,
		PCD_OUT_SHORT = 2'h2,
		PCD_OUT_FAILED = 2'h3
	} pcd_outcome_t;

	typedef enum logic [1:0] {
		PCD_ST_IDLE = 2'h0,
		PCD_ST_RUN = 2'h1,
		PCD_ST_DONE = 2'h3
	} pcd_state_t;

endpackage : pcd_pkg

/* File: pcd_diag_if.sv */
// Interface carrying one port's cable test request and result between the bank and a port slice.
interface pcd_diag_if;
	logic start;
	logic busy;
	logic [1:0] outcome;
	logic near_short_flag;
	logic [8:0] fault_count;
	logic phy_done;
	logic [1:0] phy_outcome;
	logic phy_near_short;
	logic [8:0] phy_fault_count;

	modport bank (output start, input busy, outcome, near_short_flag, fault_count);
	modport port (input start, phy_done, phy_outcome, phy_near_short, phy_fault_count,
		output busy, outcome, near_short_flag, fault_count);
endinterface : pcd_diag_if

/* File: pcd_diag_port.sv */
// One port's cable test sequencer holding the last completed result.
module pcd_diag_port (
	input wire logic ref_clk,
	input wire logic rst_n,
	pcd_diag_if.port dif
);

	// ****************************************
	// Test sequencer
	// ****************************************
	pcd_pkg::pcd_state_t st_q, st_d;
	logic [1:0] out_q, out_d;
	logic short_q, short_d;
	logic [8:0] cnt_q, cnt_d;

	always_comb begin
		st_d = st_q;
		out_d = out_q;
		short_d = short_q;
		cnt_d = cnt_q;
		case (st_q)
			pcd_pkg::PCD_ST_IDLE: begin
				if (dif.start) begin
					st_d = pcd_pkg::PCD_ST_RUN;
				end
			end
			pcd_pkg::PCD_ST_RUN: begin
				// Results are latched only at completion.
				if (dif.phy_done) begin
					out_d = dif.phy_outcome;
					short_d = dif.phy_near_short;
					cnt_d = dif.phy_fault_count;
					st_d = pcd_pkg::PCD_ST_DONE;
				end
			end
			pcd_pkg::PCD_ST_DONE: begin
				st_d = pcd_pkg::PCD_ST_IDLE;
			end
			default: begin
				st_d = pcd_pkg::PCD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q <= pcd_pkg::PCD_ST_IDLE;
			out_q <= pcd_pkg::PCD_OUT_NORMAL;
			short_q <= 1'b0;
			cnt_q <= pcd_pkg::FAULT_RST;
		end else begin
			st_q <= st_d;
			out_q <= out_d;
			short_q <= short_d;
			cnt_q <= cnt_d;
		end
	end

	// Busy drops in the same cycle that the stored results first appear.
	assign dif.busy = (st_q == pcd_pkg::PCD_ST_RUN);
	assign dif.outcome = out_q;
	assign dif.near_short_flag = short_q;
	assign dif.fault_count = cnt_q;

	// ****************************************
	// Checks
	// ****************************************
	chk_result_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == pcd_pkg::PCD_ST_RUN && !dif.phy_done)
		|=> $stable(cnt_q) && $stable(out_q) && $stable(short_q))
		else $error("Result changed while a test was running.");
	chk_result_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == pcd_pkg::PCD_ST_RUN && dif.phy_done)
		|=> cnt_q == $past(dif.phy_fault_count) && out_q == $past(dif.phy_outcome))
		else $error("Result not captured at test completion.");
	chk_short_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == pcd_pkg::PCD_ST_RUN && dif.phy_done)
		|=> short_q == $past(dif.phy_near_short) && !dif.busy)
		else $error("Near short flag not captured at completion.");

endmodule : pcd_diag_port

/* File: pcd_phy_model.sv */
// Behavioural PHY cable tester that answers start pulses after a commanded delay.
module pcd_phy_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] diag_start,
	input wire logic [7:0] cmd_delay,
	input wire logic [3:0] cmd_outcome,
	input wire logic [1:0] cmd_near,
	input wire logic [17:0] cmd_count,
	output logic [1:0] phy_done,
	output logic [3:0] phy_outcome,
	output logic [1:0] phy_near_short,
	output logic [17:0] phy_fault_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q [2];

	// ****************************************
	// Test sequencing
	// ****************************************
	// Counts down from the commanded delay and pulses done for one cycle.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 2; i++) begin
			phy_done[i] <= 1'b0;
			if (!rst_n) begin
				cnt_q[i] <= 8'h00;
			end else if (diag_start[i]) begin
				cnt_q[i] <= cmd_delay;
			end else if (cnt_q[i] == 8'h01) begin
				cnt_q[i] <= 8'h00;
				phy_done[i] <= 1'b1;
			end else if (cnt_q[i] != 8'h00) begin
				cnt_q[i] <= cnt_q[i] - 8'h01;
			end
		end
	end

	// Results are only valid in the done cycle; otherwise the inverse is shown.
	assign phy_outcome[1:0] = phy_done[0] ? cmd_outcome[1:0] : ~cmd_outcome[1:0];
	assign phy_outcome[3:2] = phy_done[1] ? cmd_outcome[3:2] : ~cmd_outcome[3:2];
	assign phy_near_short = phy_done ^ ~cmd_near;
	assign phy_fault_count[8:0] = phy_done[0] ? cmd_count[8:0] : ~cmd_count[8:0];
	assign phy_fault_count[17:9] = phy_done[1] ? cmd_count[17:9] : ~cmd_count[17:9];
endmodule : pcd_phy_model

/* File: port_cable_diag_regs_tb_top.sv */
// Self-checking testbench for the port cable diagnostic register slice.
module port_cable_diag_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] LIM_A [3] = '{pcd_pkg::P1_PRIO3_LIMIT_OFS,
		pcd_pkg::P2_PRIO3_LIMIT_OFS, pcd_pkg::P3_PRIO3_LIMIT_OFS};
	localparam logic [7:0] SPC_A [2] = '{pcd_pkg::P1_PHY_SPECIAL_OFS, pcd_pkg::P2_PHY_SPECIAL_OFS};
	localparam logic [7:0] RES_A [2] = '{pcd_pkg::P1_FAULT_DIST_OFS, pcd_pkg::P2_FAULT_DIST_OFS};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata, cmd_delay = 8'h04;
	logic [6:0] lim [3];
	logic [1:0] force_link, remote_loop, diag_start, phy_done, phy_near_short, last_ds;
	logic [1:0] cmd_near = 2'h0;
	logic [3:0] phy_outcome, cmd_outcome = 4'h0;
	logic [17:0] phy_fault_count, cmd_count = 18'h00000;
	logic [31:0] seed = 32'h00000033;
	logic [7:0] exp_ctl [2] = '{default: 8'h00};
	logic [7:0] exp_st [2] = '{default: 8'h00};
	logic [7:0] exp_res [2] = '{default: 8'h00};
	int miscompares = 0;
	int comparisons = 0;

	always #5 ref_clk = ~ref_clk;

	pcd_port_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.p1_prio3_limit(lim[0]), .p2_prio3_limit(lim[1]), .p3_prio3_limit(lim[2]),
		.force_link(force_link), .remote_loop(remote_loop), .diag_start(diag_start),
		.phy_done(phy_done), .phy_outcome(phy_outcome), .phy_near_short(phy_near_short),
		.phy_fault_count(phy_fault_count));

	pcd_phy_model phy_u (.ref_clk(ref_clk), .rst_n(rst_n), .diag_start(diag_start),
		.cmd_delay(cmd_delay), .cmd_outcome(cmd_outcome), .cmd_near(cmd_near),
		.cmd_count(cmd_count), .phy_done(phy_done), .phy_outcome(phy_outcome),
		.phy_near_short(phy_near_short), .phy_fault_count(phy_fault_count));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		last_ds = diag_start;
		@(negedge ref_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		v = reg_rdata;
		@(negedge ref_clk);
	endtask : rd

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	task automatic chk_reset_values();
		logic [7:0] v;
		chk({4'h0, force_link, remote_loop}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			rd(LIM_A[i], v);
			chk(v, 8'h00);
		end
		for (int p = 0; p < 2; p++) begin
			rd(SPC_A[p], v);
			chk(v, 8'h00);
			rd(RES_A[p], v);
			chk(v, 8'h00);
		end
	endtask : chk_reset_values

	task automatic run_tests();
		logic [7:0] v, w;
		int k;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		chk_reset_values();
		$display("Test reset values done");
		for (int n = 0; n < 12; n++) begin
			w = (n < 3) ? 8'h7F : 8'(xs()) & 8'h7F;
			wr(LIM_A[n % 3], w);
			chk({1'b0, lim[n % 3]}, w);
			rd(LIM_A[n % 3], v);
			chk(v, w);
		end
		$display("Test ingress limits done");
		for (int n = 0; n < 6; n++) begin
			w = 8'(xs()) & 8'h0A;
			exp_ctl[n % 2] = w;
			wr(SPC_A[n % 2], w);
			chk({7'h00, force_link[n % 2]}, {7'h00, w[3]});
			chk({7'h00, remote_loop[n % 2]}, {7'h00, w[1]});
			rd(SPC_A[n % 2], v);
			chk(v, w);
		end
		$display("Test control bits done");
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 4; c++) begin
				w = 8'(xs());
				cmd_outcome[p * 2 +: 2] = 2'(c);
				cmd_near[p] = w[0];
				cmd_count[p * 9 +: 9] = (c == 3) ? 9'h1FF : 9'(xs());
				cmd_delay = 8'h08 + (w & 8'h1F);
				wr(SPC_A[p], exp_ctl[p] | 8'h10);
				chk({7'h00, last_ds[p]}, 8'h01);
				wr(SPC_A[p], exp_ctl[p] | 8'h10);
				chk({7'h00, last_ds[p]}, 8'h00);
				rd(SPC_A[p], v);
				chk(v, exp_st[p] | exp_ctl[p] | 8'h10);
				rd(RES_A[p], v);
				chk(v, exp_res[p]);
				for (k = 0; k < 40; k++) begin
					rd(SPC_A[p], v);
					if (v[4] === 1'b0) begin
						break;
					end
				end
				if (k == 40) begin
					miscompares++;
					return;
				end
				exp_st[p] = {cmd_near[p], 2'(c), 4'h0, cmd_count[p * 9 + 8]};
				exp_res[p] = cmd_count[p * 9 +: 8];
				chk(v, exp_st[p] | exp_ctl[p]);
				rd(RES_A[p], v);
				chk(v, exp_res[p]);
			end
		end
		$display("Test cable diagnostics done");
		wr(pcd_pkg::P3_RSVD_SPECIAL_OFS, 8'hFF);
		wr(pcd_pkg::P3_RSVD_RESULT_OFS, 8'hFF);
		wr(RES_A[0], 8'hA5);
		wr(8'h00, 8'hFF);
		rd(pcd_pkg::P3_RSVD_SPECIAL_OFS, v);
		chk(v, 8'h00);
		rd(pcd_pkg::P3_RSVD_RESULT_OFS, v);
		chk(v, 8'h00);
		rd(RES_A[0], v);
		chk(v, exp_res[0]);
		rd(8'h00, v);
		chk(v, 8'h00);
		$display("Test reserved places done");
		cmd_delay = 8'h20;
		wr(SPC_A[0], 8'h1A);
		rst_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		chk_reset_values();
		$display("Test mid-run reset done");
	endtask : run_tests

	initial begin : main
		run_tests();
		final_report();
	end
endmodule : port_cable_diag_regs_tb_top
